//--- shared/sic_pkg.sv
package sic_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_INFO = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_IF_BIT = 0;
  localparam int CTRL_SMM_EXIT_BIT = 1;
  localparam int INFO_MULT_LSB = 0;
  localparam int INFO_CODE_LSB = 4;
  localparam int INFO_RSVD_BIT = 7;
  localparam int INFO_SMM_BIT = 8;
  localparam int INFO_FPU_BIT = 9;
  localparam int INFO_RUN_BIT = 10;

  // ----------------------------------------------------------------
  // reset values and i/o ports
  // ----------------------------------------------------------------
  localparam logic RST_IF = 1'b0;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [15:0] FPU_CLR_PORT_A = 16'h00F0;
  localparam logic [15:0] FPU_CLR_PORT_B = 16'h00F1;
  localparam logic [2:0] RATIO_TEST_CODE = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sys_mgmt_state;
    logic maskable_irq_in;
    logic fpu;
  } sic_evt_t;

  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_INVAL = 4'b0010,
    ST_RUN = 4'b0100,
    ST_SMM = 4'b1000
  } sic_state_t;

  // core clock multiplier for a ratio select code
  function automatic logic [3:0] ratio_mult(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h4;
    unique case (code)
      3'h1: m = 4'hA;
      3'h2: m = 4'h9;
      3'h3: m = 4'h5;
      3'h4: m = 4'h4;
      3'h5: m = 4'h6;
      3'h6: m = 4'h7;
      3'h7: m = 4'h8;
      3'h0: m = 4'h4;
    endcase
    return m;
  endfunction

endpackage

//--- verilog/sic_pin_sync.sv
`timescale 1ns/10ps
module sic_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] pinOut_nxt;

  // change accepted once stages two and three agree
  always_comb begin
    pinOut_nxt = pinOut;
    for (int i = 0; i < W; i++) begin
      if (stage2_r[i] == stage3_r[i]) begin
        pinOut_nxt[i] = stage3_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= INIT;
      stage2_r <= INIT;
      stage3_r <= INIT;
      pinOut <= INIT;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      pinOut <= pinOut_nxt;
    end
  end

endmodule

//--- verilog/sic_cache_inval.sv
`timescale 1ns/10ps
module sic_cache_inval #(
  parameter int LINES = 1024,
  parameter int IW = $clog2(LINES)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  output logic invStrobe,
  output logic [IW-1:0] invIdx,
  output logic done
);

  localparam logic [IW-1:0] LAST = IW'(LINES - 1);

  logic busy_r;
  logic busy_nxt;
  logic [IW-1:0] idx_nxt;
  logic done_nxt;

  // one line cleared per cycle, done rises after the last
  always_comb begin
    busy_nxt = busy_r;
    idx_nxt = invIdx;
    done_nxt = done;
    if (start) begin
      busy_nxt = 1'b1;
      idx_nxt = '0;
      done_nxt = 1'b0;
    end else if (busy_r) begin
      if (invIdx == LAST) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        idx_nxt = invIdx + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      invIdx <= '0;
      done <= 1'b0;
      invStrobe <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      invIdx <= idx_nxt;
      done <= done_nxt;
      invStrobe <= busy_nxt;
    end
  end

endmodule

//--- verilog/sic_ctrl.sv
`timescale 1ns/10ps
// Operation
// - The core multiplier follows the ratio select code: 1->10, 2->9, 3->5, 4->4, 5->6, 6->7, 7->8.
// - Reset aborts all activity and brings the core and its peripherals to a known starting state.
// - Reset marks every cache line invalid so no old cache contents survive.
// - The reset pin is asynchronous, so it is synchronised and recognised on a defined clock edge.
// - The maskable interrupt is a level; while high the core leaves its stream and enters the handler; the code ignores it in management state.
// - The maskable interrupt is ignored whenever the interrupt enable flag is clear.
// - A floating-point error drives the error interrupt output high and keeps it there until cleared.
// - An I/O write to port F0h or F1h from the handler clears the floating-point error interrupt.
// - The active-low management interrupt is a level and moves the core into management state.
module sic_ctrl #(
  parameter int CACHE_LINES = 1024,
  parameter int CIW = $clog2(CACHE_LINES)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [2:0] coreRatioSelect,
  input wire logic maskableIrqIn,
  input wire logic sysMgmtIrqN,
  input wire logic fpuErrEvent,
  input wire logic ioWrValid,
  input wire logic [15:0] ioWrAddr,
  output logic fpuErrorIrq,
  output logic intrEntry,
  output logic sysMgmtState,
  output logic [3:0] coreMultiplier,
  output logic cpuRunning,
  output logic cacheInvStrobe,
  output logic [CIW-1:0] cacheInvIdx
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic [2:0] rstSync_r;
  logic runRst;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_r <= 3'h0;
    end else begin
      rstSync_r <= {rstSync_r[1:0], 1'b1};
    end
  end
  assign runRst = rstSync_r[2];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ratioSync;
  logic intrSync;
  logic smiNSync;

  sic_pin_sync #(.W(3), .INIT(3'h4)) uRatioSync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn(coreRatioSelect),
    .pinOut(ratioSync)
  );

  sic_pin_sync #(.W(2), .INIT(2'b10)) uIrqSync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({sysMgmtIrqN, maskableIrqIn}),
    .pinOut({smiNSync, intrSync})
  );

  // ----------------------------------------------------------------
  // cache invalidation
  // ----------------------------------------------------------------
  logic invStart;
  logic invDone;

  sic_cache_inval #(.LINES(CACHE_LINES)) uInval (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(invStart),
    .invStrobe(cacheInvStrobe),
    .invIdx(cacheInvIdx),
    .done(invDone)
  );

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  sic_pkg::sic_state_t state_r, state_nxt;
  logic ifFlag_r, ifFlag_nxt;
  sic_pkg::sic_evt_t status_r, status_nxt;
  sic_pkg::sic_evt_t mask_r, mask_nxt;
  sic_pkg::sic_evt_t evt;
  logic [2:0] ratioCode_r, ratioCode_nxt;
  logic [3:0] coreMultiplier_nxt;
  logic fpuErrorIrq_nxt;
  logic intrEntry_nxt;
  logic sysMgmtState_nxt;
  logic cpuRunning_nxt;
  logic irq_nxt;
  logic waitreq_nxt;
  logic [31:0] rdata_nxt;
  logic busReq;
  logic busTake;
  logic wrTake;
  logic fpuClear;

  assign busReq = avs_read | avs_write;
  assign busTake = busReq & ~avs_waitrequest;
  assign wrTake = busTake & avs_write;
  assign invStart = runRst & (state_r == sic_pkg::ST_RESET);
  assign fpuClear = ioWrValid & ((ioWrAddr == sic_pkg::FPU_CLR_PORT_A) | (ioWrAddr == sic_pkg::FPU_CLR_PORT_B));

  always_comb begin
    state_nxt = state_r;
    ifFlag_nxt = ifFlag_r;
    mask_nxt = mask_r;
    ratioCode_nxt = ratioCode_r;
    evt = '0;
    intrEntry_nxt = 1'b0;
    fpuErrorIrq_nxt = fpuErrorIrq;
    waitreq_nxt = 1'b1;
    rdata_nxt = avs_readdata;
    unique case (state_r)
      sic_pkg::ST_RESET: begin
        // strap followed through reset and invalidation states, held once running
        ratioCode_nxt = ratioSync;
        state_nxt = sic_pkg::ST_INVAL;
      end
      sic_pkg::ST_INVAL: begin
        ratioCode_nxt = ratioSync;
        if (invDone) begin
          state_nxt = sic_pkg::ST_RUN;
        end
      end
      sic_pkg::ST_RUN: begin
        if (!smiNSync) begin
          state_nxt = sic_pkg::ST_SMM;
          evt.sys_mgmt_state = 1'b1;
        end else if (intrSync && ifFlag_r) begin
          intrEntry_nxt = 1'b1;
          ifFlag_nxt = 1'b0;
          evt.maskable_irq_in = 1'b1;
        end
      end
      sic_pkg::ST_SMM: begin
        if (wrTake && avs_address == sic_pkg::OFS_CTRL && avs_writedata[sic_pkg::CTRL_SMM_EXIT_BIT]) begin
          state_nxt = sic_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = sic_pkg::ST_RESET;
      end
    endcase
    // error held until cleared, set wins
    if (fpuClear) begin
      fpuErrorIrq_nxt = 1'b0;
    end
    if (fpuErrEvent && state_r != sic_pkg::ST_RESET && state_r != sic_pkg::ST_INVAL) begin
      fpuErrorIrq_nxt = 1'b1;
      evt.fpu = 1'b1;
    end
    status_nxt = status_r | evt;
    // bus slave: one wait cycle, answer on the next
    if (busReq && avs_waitrequest && state_r != sic_pkg::ST_RESET) begin
      waitreq_nxt = 1'b0;
      rdata_nxt = '0;
      unique case (avs_address)
        sic_pkg::OFS_CTRL: rdata_nxt[sic_pkg::CTRL_IF_BIT] = ifFlag_r;
        sic_pkg::OFS_STATUS: rdata_nxt[2:0] = status_r;
        sic_pkg::OFS_MASK: rdata_nxt[2:0] = mask_r;
        sic_pkg::OFS_INFO: begin
          rdata_nxt[sic_pkg::INFO_MULT_LSB +: 4] = coreMultiplier;
          rdata_nxt[sic_pkg::INFO_CODE_LSB +: 3] = ratioCode_r;
          rdata_nxt[sic_pkg::INFO_RSVD_BIT] = (ratioCode_r == sic_pkg::RATIO_TEST_CODE);
          rdata_nxt[sic_pkg::INFO_SMM_BIT] = sysMgmtState;
          rdata_nxt[sic_pkg::INFO_FPU_BIT] = fpuErrorIrq;
          rdata_nxt[sic_pkg::INFO_RUN_BIT] = cpuRunning;
        end
        default: rdata_nxt = '0;
      endcase
    end
    if (wrTake) begin
      unique case (avs_address)
        sic_pkg::OFS_CTRL: ifFlag_nxt = avs_writedata[sic_pkg::CTRL_IF_BIT];
        sic_pkg::OFS_STATUS: status_nxt = (status_r & ~avs_writedata[2:0]) | evt;
        sic_pkg::OFS_MASK: mask_nxt = avs_writedata[2:0];
        default: ;
      endcase
    end
    coreMultiplier_nxt = sic_pkg::ratio_mult(ratioCode_nxt);
    sysMgmtState_nxt = (state_nxt == sic_pkg::ST_SMM);
    cpuRunning_nxt = (state_nxt == sic_pkg::ST_RUN) | (state_nxt == sic_pkg::ST_SMM);
    irq_nxt = |(status_nxt & mask_nxt);
    if (!runRst) begin
      state_nxt = sic_pkg::ST_RESET;
      ifFlag_nxt = sic_pkg::RST_IF;
      status_nxt = '0;
      mask_nxt = sic_pkg::RST_MASK;
      intrEntry_nxt = 1'b0;
      fpuErrorIrq_nxt = 1'b0;
      sysMgmtState_nxt = 1'b0;
      cpuRunning_nxt = 1'b0;
      irq_nxt = 1'b0;
      waitreq_nxt = 1'b1;
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= sic_pkg::ST_RESET;
      ifFlag_r <= sic_pkg::RST_IF;
      status_r <= '0;
      mask_r <= sic_pkg::RST_MASK;
      ratioCode_r <= 3'h4;
      coreMultiplier <= 4'h4;
      fpuErrorIrq <= 1'b0;
      intrEntry <= 1'b0;
      sysMgmtState <= 1'b0;
      cpuRunning <= 1'b0;
      irq <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      ifFlag_r <= ifFlag_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ratioCode_r <= ratioCode_nxt;
      coreMultiplier <= coreMultiplier_nxt;
      fpuErrorIrq <= fpuErrorIrq_nxt;
      intrEntry <= intrEntry_nxt;
      sysMgmtState <= sysMgmtState_nxt;
      cpuRunning <= cpuRunning_nxt;
      irq <= irq_nxt;
      avs_waitrequest <= waitreq_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence busWait_s;
    busReq && avs_waitrequest && runRst && state_r != sic_pkg::ST_RESET;
  endsequence

  sequence busAnswer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence smiLow_s;
    !smiNSync && state_r == sic_pkg::ST_RUN && runRst;
  endsequence

  bus_answer_a: assert property (busWait_s |=> busAnswer_s)
    else $error("bus request not answered after one wait cycle");

  ratio_decode_a: assert property (cpuRunning && ratioCode_r == 3'h1 |-> coreMultiplier == 4'hA)
    else $error("code 001 does not give multiplier ten");

  ratio_table_a: assert property (cpuRunning |-> coreMultiplier == sic_pkg::ratio_mult(ratioCode_r))
    else $error("multiplier does not match latched code");

  reset_clears_a: assert property (!runRst |=> !cpuRunning && !fpuErrorIrq && !irq && !intrEntry)
    else $error("outputs not in known state under reset");

  reset_sync_a: assert property ($rose(rstSync_r[2]) |-> $past(rstSync_r[1], 1))
    else $error("reset released without synchroniser stages");

  inval_first_a: assert property ($rose(cpuRunning) |-> invDone)
    else $error("core ran before cache invalidation finished");

  maskable_irq_in_masked_a: assert property (runRst && !ifFlag_r |=> !intrEntry)
    else $error("interrupt taken with enable flag clear");

  maskable_irq_in_entry_a: assert property (state_r == sic_pkg::ST_RUN && smiNSync && intrSync && ifFlag_r && runRst
      |=> intrEntry ##1 !intrEntry)
    else $error("level interrupt did not enter handler");

  fpu_set_a: assert property (runRst && fpuErrEvent && cpuRunning |=> fpuErrorIrq)
    else $error("error interrupt not raised");

  fpu_hold_a: assert property (fpuErrorIrq && !fpuClear && runRst |=> fpuErrorIrq)
    else $error("error interrupt dropped without clearing write");

  fpu_clear_a: assert property (fpuClear && !fpuErrEvent && runRst |=> !fpuErrorIrq)
    else $error("port write did not clear error interrupt");

  smm_entry_a: assert property (smiLow_s |=> sysMgmtState ##1 sysMgmtState)
    else $error("management interrupt did not enter management state");

endmodule

//--- verif/sic_chipset_model.sv
`timescale 1ns/10ps
module sic_chipset_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] ratioReq,
  input wire logic intrReq,
  input wire logic smiReq,
  input wire logic ioReq,
  input wire logic [15:0] ioAddrReq,
  output logic [2:0] coreRatioSelect,
  output logic maskableIrqIn,
  output logic sysMgmtIrqN,
  output logic ioWrValid,
  output logic [15:0] ioWrAddr
);
  initial begin
    coreRatioSelect = 3'h4;
    maskableIrqIn = 1'b0;
    sysMgmtIrqN = 1'b1;
    ioWrValid = 1'b0;
    ioWrAddr = 16'h0000;
  end

  always @(posedge clk_sys) begin
    // strap only under reset, never test code
    if (!rst_b && ratioReq != 3'h0) begin
      coreRatioSelect <= ratioReq;
    end
    maskableIrqIn <= intrReq;
    sysMgmtIrqN <= ~smiReq;
    ioWrValid <= ioReq;
    // released address bus toggles between the last value and its inverse
    ioWrAddr <= ioReq ? ioAddrReq : ~ioWrAddr;
  end
endmodule

//--- verif/sic_ctrl_bench.sv
`timescale 1ns/10ps
module sic_ctrl_bench;
  localparam int LINES = 8;
  localparam logic [3:0] MULT_TAB [8] = '{4'h4, 4'hA, 4'h9, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
  logic clk_sys = 1'b0;
  logic rstB = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [31:0] avsReaddata;
  logic [31:0] rdData;
  logic avsWaitrequest, irq, fpuErrorIrq, intrEntry, sysMgmtState, cpuRunning, cacheInvStrobe;
  logic fpuErrEvent = 1'b0;
  logic [3:0] coreMultiplier;
  logic [2:0] ratioReq = 3'h4;
  logic [2:0] coreRatioSelect;
  logic intrReq = 1'b0;
  logic smiReq = 1'b0;
  logic ioReq = 1'b0;
  logic [15:0] ioAddrReq = 16'h0000;
  logic [15:0] ioWrAddr;
  logic maskableIrqIn, sysMgmtIrqN, ioWrValid;
  logic [2:0] cacheInvIdx;
  logic [LINES-1:0] invSeen;
  int invCnt, intrCnt, n;
  int errorCnt = 0;
  int checked = 0;

  sic_ctrl #(.CACHE_LINES(LINES)) DUT (.clk_sys(clk_sys), .rst_b(rstB), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .irq(irq), .coreRatioSelect(coreRatioSelect),
    .maskableIrqIn(maskableIrqIn), .sysMgmtIrqN(sysMgmtIrqN), .fpuErrEvent(fpuErrEvent),
    .ioWrValid(ioWrValid), .ioWrAddr(ioWrAddr), .fpuErrorIrq(fpuErrorIrq), .intrEntry(intrEntry),
    .sysMgmtState(sysMgmtState), .coreMultiplier(coreMultiplier), .cpuRunning(cpuRunning),
    .cacheInvStrobe(cacheInvStrobe), .cacheInvIdx(cacheInvIdx));

  sic_chipset_model model (.clk_sys(clk_sys), .rst_b(rstB), .ratioReq(ratioReq), .intrReq(intrReq),
    .smiReq(smiReq), .ioReq(ioReq), .ioAddrReq(ioAddrReq), .coreRatioSelect(coreRatioSelect),
    .maskableIrqIn(maskableIrqIn), .sysMgmtIrqN(sysMgmtIrqN), .ioWrValid(ioWrValid), .ioWrAddr(ioWrAddr));

  // ----------------------------------------------------------------
  // clock and event counters
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  always @(negedge clk_sys) begin
    if (cacheInvStrobe === 1'b1) begin
      invCnt++;
      invSeen[cacheInvIdx] = 1'b1;
    end
    if (intrEntry === 1'b1) begin
      intrCnt++;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWritedata <= d;
    avsRead <= ~wr;
    avsWrite <= wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avsWaitrequest !== 1'b0 && k < 20);
    rdData = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (k >= 20) chk(32'h0000_0000, 32'h0000_0001, "bus timeout");
  endtask

  task io_wr(input logic [15:0] a);
    @(posedge clk_sys);
    ioReq <= 1'b1;
    ioAddrReq <= a;
    @(posedge clk_sys);
    ioReq <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task do_reset(input logic [2:0] code);
    rstB <= 1'b0;
    ratioReq <= code;
    intrReq <= 1'b0;
    smiReq <= 1'b0;
    fpuErrEvent <= 1'b0;
    repeat (6) @(posedge clk_sys);
    invCnt = 0;
    invSeen = '0;
    intrCnt = 0;
    chk({avsWaitrequest, fpuErrorIrq, irq, sysMgmtState, cpuRunning, coreMultiplier}, 9'h104, "reset");
    rstB <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(invCnt, 0, "early invalidate");
    for (n = 0; n < 40 && cpuRunning !== 1'b1; n++) @(posedge clk_sys);
    chk(invCnt, LINES, "lines invalidated");
    chk(invSeen, 8'hFF, "line indices");
  endtask

  task close_out;
    if (errorCnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    for (int c = 1; c < 8; c++) begin
      do_reset(3'(c));
      chk(coreMultiplier, MULT_TAB[c], "multiplier");
      bus_op(1'b0, sic_pkg::OFS_INFO, 32'h0000_0000);
      chk(rdData, (32'h1 << sic_pkg::INFO_RUN_BIT) | (c << sic_pkg::INFO_CODE_LSB) | MULT_TAB[c], "info");
    end
    bus_op(1'b0, 4'h2, 32'h0000_0000);
    chk(rdData, 32'h0000_0000, "unmapped");
    intrReq <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(intrCnt, 0, "maskable_irq_in while disabled");
    bus_op(1'b1, sic_pkg::OFS_CTRL, 32'h0000_0001);
    for (n = 0; n < 12 && intrCnt == 0; n++) @(posedge clk_sys);
    chk(intrCnt, 1, "maskable_irq_in entry");
    bus_op(1'b0, sic_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rdData, 32'h0000_0002, "maskable_irq_in status");
    intrReq <= 1'b0;
    bus_op(1'b1, sic_pkg::OFS_STATUS, 32'h0000_0007);
    for (int p = 0; p < 2; p++) begin
      bus_op(1'b1, sic_pkg::OFS_MASK, (p == 0) ? 32'h0000_0001 : 32'h0000_0000);
      @(posedge clk_sys);
      fpuErrEvent <= 1'b1;
      @(posedge clk_sys);
      fpuErrEvent <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk({fpuErrorIrq, irq}, {1'b1, p == 0}, "fpu error irq");
      io_wr(16'h00F2);
      chk(fpuErrorIrq, 1'b1, "other port cleared");
      io_wr(p ? sic_pkg::FPU_CLR_PORT_B : sic_pkg::FPU_CLR_PORT_A);
      chk(fpuErrorIrq, 1'b0, "port clear");
      bus_op(1'b1, sic_pkg::OFS_STATUS, 32'h0000_0001);
      @(posedge clk_sys);
      chk(irq, 1'b0, "status cleared");
    end
    smiReq <= 1'b1;
    for (n = 0; n < 12 && sysMgmtState !== 1'b1; n++) @(posedge clk_sys);
    chk(sysMgmtState, 1'b1, "mgmt entry");
    bus_op(1'b1, sic_pkg::OFS_CTRL, 32'h0000_0001);
    intrReq <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(intrCnt, 1, "maskable_irq_in in mgmt");
    intrReq <= 1'b0;
    smiReq <= 1'b0;
    repeat (6) @(posedge clk_sys);
    bus_op(1'b1, sic_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk(sysMgmtState, 1'b0, "mgmt exit");
    fpuErrEvent <= 1'b1;
    @(posedge clk_sys);
    fpuErrEvent <= 1'b0;
    do_reset(3'h5);
    chk(coreMultiplier, 4'h6, "multiplier after reset");
    close_out;
  end

  initial begin
    repeat (4000) @(posedge clk_sys);
    errorCnt++;
    close_out;
  end
endmodule
